// file: pmm_monitor.sv
// Stand-still, axis-range and tool-zone monitors with their register file.
// Assumes measurement samples and register accesses arrive on i_clk_sys.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module pmm_monitor #(
    parameter int SETTLE_CYC = pmm_pkg::SETTLE_CYC
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_b,
    input  wire pmm_pkg::pmm_bus_t      i_bus,
    output logic [pmm_pkg::DW-1:0]      o_rdata,
    input  wire pmm_pkg::pmm_meas_t     i_meas,
    output logic [pmm_pkg::N_SS-1:0]    o_ss_out,
    output logic [pmm_pkg::N_AR-1:0]    o_ar_out,
    output logic [pmm_pkg::N_TZ-1:0]    o_tz_out
);
    localparam int DW = pmm_pkg::DW;
    localparam int AW = pmm_pkg::AW;
    localparam int NA = pmm_pkg::N_AX;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [DW-1:0] ss_tol_q;
    logic [DW-1:0] ss_dly_q;
    logic [DW-1:0] ss_cfg_q  [pmm_pkg::N_SS];
    logic [DW-1:0] ar_cfg_q  [pmm_pkg::N_AR];
    logic [DW-1:0] ar_lo_q   [pmm_pkg::N_AR][NA];
    logic [DW-1:0] ar_hi_q   [pmm_pkg::N_AR][NA];
    logic [DW-1:0] tz_cfg_q  [pmm_pkg::N_TZ];
    logic [DW-1:0] tz_vtcp_q [pmm_pkg::N_TZ];
    logic [DW-1:0] tz_velb_q [pmm_pkg::N_TZ];
    logic [DW-1:0] tz_ori_q  [pmm_pkg::N_TZ];
    logic [DW-1:0] tz_lo_q   [pmm_pkg::N_TZ][pmm_pkg::N_ADD];
    logic [DW-1:0] tz_hi_q   [pmm_pkg::N_TZ][pmm_pkg::N_ADD];

    logic [AW-1:0] ar_off;
    logic [AW-1:0] tz_off;
    logic [2:0]    ar_set;
    logic [3:0]    ar_ax;
    logic [2:0]    tz_z;
    logic [1:0]    tz_ax;
    logic [2:0]    cfg_i;
    assign ar_off = i_bus.addr - pmm_pkg::A_AR_LIM;
    assign tz_off = i_bus.addr - pmm_pkg::A_TZ_LIM;
    assign ar_set = ar_off[9:7];
    assign ar_ax  = ar_off[6:3];
    assign tz_z   = tz_off[7:5];
    assign tz_ax  = tz_off[4:3];
    assign cfg_i  = i_bus.addr[4:2];

    // Range limits live only in this block, apart from any stop ranges.
    // [R9] [R11] Per-axis limits stored.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ss_tol_q <= pmm_pkg::SS_TOL_RST;
            ss_dly_q <= DW'(SETTLE_CYC);
            for (int i = 0; i < pmm_pkg::N_SS; i++) begin
                ss_cfg_q[i] <= '0;
            end
            for (int i = 0; i < pmm_pkg::N_AR; i++) begin
                ar_cfg_q[i] <= '0;
                for (int a = 0; a < NA; a++) begin
                    ar_lo_q[i][a] <= '0;
                    ar_hi_q[i][a] <= '0;
                end
            end
            for (int i = 0; i < pmm_pkg::N_TZ; i++) begin
                tz_cfg_q[i]  <= '0;
                tz_vtcp_q[i] <= '0;
                tz_velb_q[i] <= '0;
                tz_ori_q[i]  <= '0;
                for (int a = 0; a < pmm_pkg::N_ADD; a++) begin
                    tz_lo_q[i][a] <= '0;
                    tz_hi_q[i][a] <= '0;
                end
            end
        end else if (i_bus.we) begin
            if (i_bus.addr == pmm_pkg::A_SS_TOL) begin
                ss_tol_q <= i_bus.wdata;
            end else if (i_bus.addr == pmm_pkg::A_SS_DLY) begin
                ss_dly_q <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_SS_CFG && i_bus.addr < pmm_pkg::A_SS_CFG + 12'h010) begin
                ss_cfg_q[cfg_i[1:0]] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_AR_CFG && i_bus.addr < pmm_pkg::A_AR_CFG + 12'h020) begin
                ar_cfg_q[cfg_i] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_TZ_CFG && i_bus.addr < pmm_pkg::A_TZ_VTCP) begin
                tz_cfg_q[cfg_i] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_TZ_VTCP && i_bus.addr < pmm_pkg::A_TZ_VELB) begin
                tz_vtcp_q[cfg_i] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_TZ_VELB && i_bus.addr < pmm_pkg::A_TZ_ORI) begin
                tz_velb_q[cfg_i] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_TZ_ORI && i_bus.addr < pmm_pkg::A_TZ_ORI + 12'h020) begin
                tz_ori_q[cfg_i] <= i_bus.wdata;
            end else if (i_bus.addr >= pmm_pkg::A_AR_LIM && i_bus.addr < pmm_pkg::A_TZ_LIM && ar_ax < 4'(NA)) begin
                if (ar_off[2]) begin
                    ar_hi_q[ar_set][ar_ax] <= i_bus.wdata;
                end else begin
                    ar_lo_q[ar_set][ar_ax] <= i_bus.wdata;
                end
            end else if (i_bus.addr >= pmm_pkg::A_TZ_LIM && i_bus.addr < pmm_pkg::A_END
                         && tz_ax < 2'(pmm_pkg::N_ADD)) begin
                if (tz_off[2]) begin
                    tz_hi_q[tz_z][tz_ax] <= i_bus.wdata;
                end else begin
                    tz_lo_q[tz_z][tz_ax] <= i_bus.wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stand-still monitor
    // ------------------------------------------------------------
    // No enable input exists, so the monitor always runs.
    logic [DW-1:0]             prev_q [NA];
    logic [NA-1:0]             ax_mov;
    logic [pmm_pkg::N_SS-1:0]  set_mov;
    logic [pmm_pkg::N_SS-1:0]  still_q;
    logic [DW-1:0]             cnt_q  [pmm_pkg::N_SS];
    logic                      done_q;

    // [R3] Per-axis motion detect.
    always_comb begin
        for (int a = 0; a < NA; a++) begin
            logic signed [DW-1:0] dlt;
            dlt = $signed(i_meas.pos[a]) - $signed(prev_q[a]);
            if (dlt < 0) begin
                dlt = -dlt;
            end
            ax_mov[a] = $unsigned(dlt) > ss_tol_q;
        end
        for (int s = 0; s < pmm_pkg::N_SS; s++) begin
            set_mov[s] = i_meas.valid && |(ax_mov & ss_cfg_q[s][NA-1:0]);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int a = 0; a < NA; a++) begin
                prev_q[a] <= '0;
            end
        end else if (i_meas.valid) begin
            for (int a = 0; a < NA; a++) begin
                prev_q[a] <= i_meas.pos[a];
            end
        end
    end

    // [R19] First evaluation flag.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_q <= 1'b0;
        end else if (i_meas.valid) begin
            done_q <= 1'b1;
        end
    end

    // A fresh motion restarts the count, so a jittering axis keeps the output low.
    // [R1] [R2] [R5] [R18] Drop and settle.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int s = 0; s < pmm_pkg::N_SS; s++) begin
                still_q[s] <= 1'b0;
                cnt_q[s]   <= '0;
            end
        end else begin
            for (int s = 0; s < pmm_pkg::N_SS; s++) begin
                if (set_mov[s]) begin
                    still_q[s] <= 1'b0;
                    cnt_q[s]   <= '0;
                end else if (cnt_q[s] >= ss_dly_q) begin
                    still_q[s] <= 1'b1;
                end else begin
                    cnt_q[s] <= cnt_q[s] + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Axis-range and tool-zone evaluation
    // ------------------------------------------------------------
    logic [pmm_pkg::N_AR-1:0] ar_eval;
    logic [pmm_pkg::N_TZ-1:0] tz_add_ok;
    logic [pmm_pkg::N_TZ-1:0] tz_eval;
    logic [pmm_pkg::N_AR-1:0] ar_ok_q;
    logic [pmm_pkg::N_TZ-1:0] tz_ok_q;

    // [R6] [R7] [R9] [R10] [R12] Range check.
    always_comb begin
        for (int k = 0; k < pmm_pkg::N_AR; k++) begin
            logic [NA-1:0] inr;
            for (int a = 0; a < NA; a++) begin
                logic signed [DW-1:0] p;
                logic signed [DW-1:0] lo;
                logic signed [DW-1:0] hi;
                p  = $signed(i_meas.pos[a]);
                lo = $signed(ar_lo_q[k][a]);
                hi = $signed(ar_hi_q[k][a]);
                if (ar_cfg_q[k][pmm_pkg::F_AR_ALW]) begin
                    inr[a] = (p >= lo) && (p <= hi);
                end else begin
                    inr[a] = (p > lo) && (p < hi);
                end
                inr[a] = inr[a] ^ ar_cfg_q[k][pmm_pkg::F_AR_INV + a];
            end
            ar_eval[k] = &(inr | ~ar_cfg_q[k][NA-1:0]);
        end
    end

    // [R13] [R14] [R15] Zone check.
    always_comb begin
        for (int z = 0; z < pmm_pkg::N_TZ; z++) begin
            tz_add_ok[z] = 1'b1;
            for (int a = 0; a < pmm_pkg::N_ADD; a++) begin
                if (tz_cfg_q[z][pmm_pkg::F_TZ_ADD + a]
                    && ($signed(i_meas.pos[pmm_pkg::ADD_BASE + a]) < $signed(tz_lo_q[z][a])
                    ||  $signed(i_meas.pos[pmm_pkg::ADD_BASE + a]) > $signed(tz_hi_q[z][a]))) begin
                    tz_add_ok[z] = 1'b0;
                end
            end
            tz_eval[z] = (i_meas.in_shape[z] == tz_cfg_q[z][pmm_pkg::F_TZ_IN])
                && (DW'(i_meas.tcp_speed) <= tz_vtcp_q[z])
                && (DW'(i_meas.elb_speed) <= tz_velb_q[z])
                && (DW'(i_meas.ori_dev[z]) <= tz_ori_q[z])
                && tz_add_ok[z];
        end
    end

    // [R17] Always evaluated.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ar_ok_q <= '0;
            tz_ok_q <= '0;
        end else if (i_meas.valid) begin
            ar_ok_q <= ar_eval;
            tz_ok_q <= tz_eval;
        end
    end

    // ------------------------------------------------------------
    // Output mapping
    // ------------------------------------------------------------
    // An output with no set mapped to it stays low: low never claims anything.
    logic [pmm_pkg::N_SS-1:0] ss_out_d;
    logic [pmm_pkg::N_AR-1:0] ar_out_d;
    logic [pmm_pkg::N_TZ-1:0] tz_out_d;
    logic [pmm_pkg::N_SS-1:0] ss_out_q;
    logic [pmm_pkg::N_AR-1:0] ar_out_q;
    logic [pmm_pkg::N_TZ-1:0] tz_out_q;

    // [R4] [R12] Sets to outputs.
    always_comb begin
        ss_out_d = '0;
        ar_out_d = '0;
        tz_out_d = '0;
        for (int j = 0; j < pmm_pkg::N_SS; j++) begin
            logic used;
            logic ok;
            used = 1'b0;
            ok   = 1'b1;
            for (int s = 0; s < pmm_pkg::N_SS; s++) begin
                if (ss_cfg_q[s][pmm_pkg::F_SS_EN] && ss_cfg_q[s][pmm_pkg::F_SS_SEL +: 2] == 2'(j)) begin
                    used = 1'b1;
                    ok   = ok & still_q[s];
                end
            end
            ss_out_d[j] = used & ok;
        end
        for (int j = 0; j < pmm_pkg::N_AR; j++) begin
            logic used;
            logic ok;
            used = 1'b0;
            ok   = 1'b1;
            for (int k = 0; k < pmm_pkg::N_AR; k++) begin
                if (ar_cfg_q[k][pmm_pkg::F_AR_EN] && ar_cfg_q[k][pmm_pkg::F_AR_SEL +: 3] == 3'(j)) begin
                    used = 1'b1;
                    ok   = ok & ar_ok_q[k];
                end
                if (tz_cfg_q[k][pmm_pkg::F_TZ_EN] && tz_cfg_q[k][pmm_pkg::F_TZ_SEL +: 3] == 3'(j)) begin
                    tz_out_d[j] = 1'b1;
                end
            end
            ar_out_d[j] = used & ok;
        end
        for (int j = 0; j < pmm_pkg::N_TZ; j++) begin
            for (int z = 0; z < pmm_pkg::N_TZ; z++) begin
                if (tz_cfg_q[z][pmm_pkg::F_TZ_EN] && tz_cfg_q[z][pmm_pkg::F_TZ_SEL +: 3] == 3'(j)
                    && !tz_ok_q[z]) begin
                    tz_out_d[j] = 1'b0;
                end
            end
        end
    end

    // [R19] Gate until evaluated.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ss_out_q <= '0;
            ar_out_q <= '0;
            tz_out_q <= '0;
        end else begin
            ss_out_q <= done_q ? ss_out_d : '0;
            ar_out_q <= done_q ? ar_out_d : '0;
            tz_out_q <= done_q ? tz_out_d : '0;
        end
    end
    assign o_ss_out = ss_out_q;
    assign o_ar_out = ar_out_q;
    assign o_tz_out = tz_out_q;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [DW-1:0] rd_d;
    logic [DW-1:0] rdata_q;

    always_comb begin
        rd_d = '0;
        if (i_bus.addr == pmm_pkg::A_STATUS) begin
            rd_d = {11'h000, done_q, tz_out_q, ar_out_q, ss_out_q};
        end else if (i_bus.addr == pmm_pkg::A_SS_TOL) begin
            rd_d = ss_tol_q;
        end else if (i_bus.addr == pmm_pkg::A_SS_DLY) begin
            rd_d = ss_dly_q;
        end else if (i_bus.addr >= pmm_pkg::A_SS_CFG && i_bus.addr < pmm_pkg::A_SS_CFG + 12'h010) begin
            rd_d = ss_cfg_q[cfg_i[1:0]];
        end else if (i_bus.addr >= pmm_pkg::A_AR_CFG && i_bus.addr < pmm_pkg::A_AR_CFG + 12'h020) begin
            rd_d = ar_cfg_q[cfg_i];
        end else if (i_bus.addr >= pmm_pkg::A_TZ_CFG && i_bus.addr < pmm_pkg::A_TZ_VTCP) begin
            rd_d = tz_cfg_q[cfg_i];
        end else if (i_bus.addr >= pmm_pkg::A_TZ_VTCP && i_bus.addr < pmm_pkg::A_TZ_VELB) begin
            rd_d = tz_vtcp_q[cfg_i];
        end else if (i_bus.addr >= pmm_pkg::A_TZ_VELB && i_bus.addr < pmm_pkg::A_TZ_ORI) begin
            rd_d = tz_velb_q[cfg_i];
        end else if (i_bus.addr >= pmm_pkg::A_TZ_ORI && i_bus.addr < pmm_pkg::A_TZ_ORI + 12'h020) begin
            rd_d = tz_ori_q[cfg_i];
        end else if (i_bus.addr >= pmm_pkg::A_AR_LIM && i_bus.addr < pmm_pkg::A_TZ_LIM && ar_ax < 4'(NA)) begin
            rd_d = ar_off[2] ? ar_hi_q[ar_set][ar_ax] : ar_lo_q[ar_set][ar_ax];
        end else if (i_bus.addr >= pmm_pkg::A_TZ_LIM && i_bus.addr < pmm_pkg::A_END
                     && tz_ax < 2'(pmm_pkg::N_ADD)) begin
            rd_d = tz_off[2] ? tz_hi_q[tz_z][tz_ax] : tz_lo_q[tz_z][tz_ax];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_bus.re ? rd_d : '0;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    for (genvar s = 0; s < pmm_pkg::N_SS; s++) begin : g_ss_chk
        AST_SS_DROP: assert property (set_mov[s] |=> !still_q[s]) // [R1]
            else $error("Stand-still flag stayed high after motion.");
        AST_SS_SETTLE: assert property ($rose(still_q[s]) |-> $past(cnt_q[s]) >= ss_dly_q) // [R2]
            else $error("Stand-still flag rose before settling.");
        AST_SS_OUT: assert property (set_mov[s] && ss_cfg_q[s][pmm_pkg::F_SS_EN] ##0 // [R4]
            (ss_cfg_q[s][pmm_pkg::F_SS_SEL +: 2] == 2'(s)) ##2 1'b1 |-> !o_ss_out[s])
            else $error("Mapped stand-still output stayed high on motion.");
    end

    for (genvar k = 0; k < pmm_pkg::N_AR; k++) begin : g_ar_chk
        AST_AR_LOW: assert property (i_meas.valid && !ar_eval[k] |=> !ar_ok_q[k]) // [R12]
            else $error("Range set ok despite an axis out of range.");
        AST_AR_HIGH: assert property (i_meas.valid && ar_eval[k] |=> ar_ok_q[k]) // [R7]
            else $error("Range set not ok with all axes in range.");
        AST_TZ_SPEED: assert property (i_meas.valid && DW'(i_meas.tcp_speed) > tz_vtcp_q[k] // [R14]
            |=> !tz_ok_q[k])
            else $error("Zone ok despite tool speed over limit.");
        AST_TZ_ADD: assert property (i_meas.valid && !tz_add_ok[k] |=> !tz_ok_q[k]) // [R15]
            else $error("Zone ok despite additional axis out of range.");
    end

    AST_RST_LOW: assert property (!done_q |=> (o_ss_out == '0 && o_ar_out == '0 && o_tz_out == '0)) // [R19]
        else $error("Output high before first evaluation.");

    COV_SS_SETTLE: cover property (set_mov[0] ##1 !set_mov[0] [*8] ##[1:300] o_ss_out[0]);
    COV_AR_HIGH: cover property (o_ar_out[0] ##1 !o_ar_out[0]);
    COV_TZ_HIGH: cover property (i_meas.valid ##2 o_tz_out[0]);
endmodule

// file: pmm_pkg.sv
// Constants, register map and carrier types of the passive motion monitor.
// Assumes one 100 MHz clock shared with the measurement path and the register port.
// Functional notes
// [R1] Stand-still output drops when any axis moves.
// [R2] Stand-still output returns high after settling.
// [R3] Four stand-still sets, nine axes each.
// [R4] Per set: axis mask and output select.
// [R5] Stand-still monitor has no off switch.
// [R6] Eight axis-range sets, nine axes each.
// [R7] Range output high only when all inside.
// [R8] Receiver trusts high only, never low.
// [R9] Per-axis range limits and invert flag.
// [R10] Per-set allow-inside option applied.
// [R11] Ranges kept apart from stop ranges.
// [R12] Any axis out drops shared output.
// [R13] Eight zones: shape, orientation, speed limits.
// [R14] Any zone violation drives output low.
// [R15] Zones also check additional axis ranges.
// [R16] Manual mode keeps speeds within limit.
// [R17] Tool-zone monitor has no off switch.
// [R18] Settling delay counts cycles, restarts on motion.
// [R19] Outputs low until first evaluation done.
package pmm_pkg;
    localparam int N_AX     = 9;
    localparam int N_SS     = 4;
    localparam int N_AR     = 8;
    localparam int N_TZ     = 8;
    localparam int N_ADD    = 3;
    localparam int ADD_BASE = 6;
    localparam int AW       = 12;
    localparam int DW       = 32;
    localparam int SW       = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_STATUS  = 12'h000;
    localparam logic [AW-1:0] A_SS_TOL  = 12'h004;
    localparam logic [AW-1:0] A_SS_DLY  = 12'h008;
    localparam logic [AW-1:0] A_SS_CFG  = 12'h010;
    localparam logic [AW-1:0] A_AR_CFG  = 12'h040;
    localparam logic [AW-1:0] A_TZ_CFG  = 12'h080;
    localparam logic [AW-1:0] A_TZ_VTCP = 12'h0A0;
    localparam logic [AW-1:0] A_TZ_VELB = 12'h0C0;
    localparam logic [AW-1:0] A_TZ_ORI  = 12'h0E0;
    localparam logic [AW-1:0] A_AR_LIM  = 12'h200;
    localparam logic [AW-1:0] A_TZ_LIM  = 12'h600;
    localparam logic [AW-1:0] A_END     = 12'h700;

    // Field positions.
    localparam int F_SS_SEL = 9;
    localparam int F_SS_EN  = 11;
    localparam int F_AR_INV = 9;
    localparam int F_AR_ALW = 18;
    localparam int F_AR_SEL = 19;
    localparam int F_AR_EN  = 22;
    localparam int F_TZ_IN  = 0;
    localparam int F_TZ_EN  = 1;
    localparam int F_TZ_ADD = 2;
    localparam int F_TZ_SEL = 5;

    localparam logic [DW-1:0] SS_TOL_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                    we;
        logic                    re;
        logic [AW-1:0]           addr;
        logic [DW-1:0]           wdata;
    } pmm_bus_t;

    typedef struct packed {
        logic                    valid;
        logic [N_AX-1:0][DW-1:0] pos;
        logic [N_TZ-1:0]         in_shape;
        logic [N_TZ-1:0][SW-1:0] ori_dev;
        logic [SW-1:0]           tcp_speed;
        logic [SW-1:0]           elb_speed;
    } pmm_meas_t;
endpackage

// file: pmm_plc_model.sv
// Far-side model: a safety PLC that reads the monitor's axis-range and tool-zone outputs.
// Assumes the outputs are same-clock levels, sampled on i_clk_sys.
`timescale 1ns/1ps
module pmm_plc_model (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst_b,
    input  wire logic [pmm_pkg::N_AR-1:0] i_ar_out,
    input  wire logic [pmm_pkg::N_TZ-1:0] i_tz_out,
    output logic      [pmm_pkg::N_AR-1:0] o_ar_proven,
    output logic      [pmm_pkg::N_TZ-1:0] o_tz_proven
);
    // ------------------------------------------------------------
    // Proof register
    // ------------------------------------------------------------
    // High proves inside
    // A low output makes no claim about position, so only highs are recorded as proof.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ar_proven <= '0;
            o_tz_proven <= '0;
        end else begin
            o_ar_proven <= i_ar_out;
            o_tz_proven <= i_tz_out;
        end
    end
endmodule

// file: passive_motion_monitor_tb.sv
// Self-checking bench for the passive motion monitor and its PLC partner.
// Assumes one clock; the settling count is shortened to 4 cycles.
`timescale 1ns/1ps
module passive_motion_monitor_tb;
    typedef struct {int p2; int p3; int p6; int tcp; int elb; int ori; bit shp; bit ear; bit etz;} pmm_row_t;
    logic                     clk_sys = 1'b0;
    logic                     rst_b   = 1'b0;
    pmm_pkg::pmm_bus_t        bus     = '0;
    pmm_pkg::pmm_meas_t       meas    = '0;
    logic [pmm_pkg::DW-1:0]   rdata;
    logic [pmm_pkg::N_SS-1:0] ss_out;
    logic [pmm_pkg::N_AR-1:0] ar_out, plc_ar;
    logic [pmm_pkg::N_TZ-1:0] tz_out, plc_tz;
    int                       num_errors = 0;
    int                       tests_run  = 0;
    int                       cycles     = 0;
    // Speeds stay at 200 in passing rows, as a manual-mode controller would keep them.
    // Speeds kept low except in rows[6] and rows[7], which raise one speed to 300
    pmm_row_t rows [11] = '{'{0, 10, 500, 200, 200, 5, 1, 1, 1}, '{100, 50, 500, 200, 200, 5, 1, 1, 1},
        '{101, 10, 500, 200, 200, 5, 1, 0, 1}, '{0, 51, 500, 200, 200, 5, 1, 0, 1},
        '{-100, 0, 500, 200, 200, 5, 1, 1, 1}, '{-101, 0, 500, 200, 200, 5, 1, 0, 1},
        '{0, 10, 500, 300, 200, 5, 1, 1, 0}, '{0, 10, 500, 200, 300, 5, 1, 1, 0},
        '{0, 10, 500, 200, 200, 20, 1, 1, 0}, '{0, 10, 500, 200, 200, 5, 0, 1, 0},
        '{0, 10, 2000, 200, 200, 5, 1, 1, 0}};

    always #5 clk_sys = ~clk_sys;

    pmm_monitor #(.SETTLE_CYC(4)) dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_meas(meas), .o_ss_out(ss_out), .o_ar_out(ar_out), .o_tz_out(tz_out));
    pmm_plc_model plc (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_ar_out(ar_out), .i_tz_out(tz_out),
        .o_ar_proven(plc_ar), .o_tz_proven(plc_tz));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_sys);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask

    task automatic put(input pmm_row_t r);
        @(posedge clk_sys);
        meas.pos[2]      <= 32'(r.p2);
        meas.pos[3]      <= 32'(r.p3);
        meas.pos[6]      <= 32'(r.p6);
        meas.tcp_speed   <= 16'(r.tcp);
        meas.elb_speed   <= 16'(r.elb);
        meas.ori_dev[0]  <= 16'(r.ori);
        meas.in_shape[0] <= r.shp;
        repeat (5) @(posedge clk_sys);
        #1 chk(32'(ar_out[0]), 32'(r.ear));
        chk(32'(tz_out[0]), 32'(r.etz));
        chk(32'(plc_ar[0]), 32'(r.ear));
        chk(32'(plc_tz[0]), 32'(r.etz));
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(pmm_pkg::A_SS_DLY, 32'h0000_0004);
        rd_chk(pmm_pkg::A_END, 32'h0000_0000);
        chk(32'({ss_out, ar_out, tz_out}), 32'h0000_0000);
        for (int k = 0; k < 4; k++) wr(pmm_pkg::A_SS_CFG + 12'(4 * k), 32'h800 | (k << 9) | (1 << k));
        wr(pmm_pkg::A_AR_CFG, 32'h0044_000C);
        wr(12'h210, -32'sd100);
        wr(12'h214, 32'h0000_0064);
        wr(12'h218, 32'h0000_0000);
        wr(12'h21C, 32'h0000_0032);
        wr(pmm_pkg::A_TZ_CFG, 32'h0000_0007);
        wr(pmm_pkg::A_TZ_VTCP, 32'h0000_00FA);
        wr(pmm_pkg::A_TZ_VELB, 32'h0000_00FA);
        wr(pmm_pkg::A_TZ_ORI, 32'h0000_000A);
        wr(pmm_pkg::A_TZ_LIM + 12'h004, 32'h0000_03E8);
        meas.valid <= 1'b1;
        repeat (20) @(posedge clk_sys);
        meas.pos[0] <= 32'h0000_0001;
        #1 chk(32'(ss_out), 32'h0000_000F);
        repeat (3) @(posedge clk_sys);
        meas.pos[0] <= 32'h0000_0002;
        #1 chk(32'(ss_out), 32'h0000_000E);
        repeat (4) @(posedge clk_sys);
        #1 chk(32'(ss_out), 32'h0000_000E);
        repeat (20) @(posedge clk_sys);
        #1 chk(32'(ss_out), 32'h0000_000F);
        foreach (rows[i]) put(rows[i]);
        wr(pmm_pkg::A_AR_CFG, 32'h0044_100C);
        put('{0, 60, 500, 200, 200, 5, 1, 1, 1});
        wr(pmm_pkg::A_AR_CFG, 32'h0040_000C);
        put('{100, 50, 500, 200, 200, 5, 1, 0, 1});
        wr(pmm_pkg::A_TZ_CFG, 32'h0000_0006);
        put('{0, 10, 500, 200, 200, 5, 0, 1, 1});
        // Mid-run reset: configuration clears and outputs wait for a fresh sample.
        @(posedge clk_sys);
        rst_b      <= 1'b0;
        meas.valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk(32'({ss_out, ar_out, tz_out}), 32'h0000_0000);
        rd_chk(pmm_pkg::A_STATUS, 32'h0000_0000);
        @(posedge clk_sys);
        meas.valid <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(pmm_pkg::A_STATUS, 32'h0010_0000);
        tally_and_finish();
    end
endmodule
